//--- rtl/bns_store.sv
// byte nonvolatile store: request engine, wear levelling, timing
//
// Overview of operation
// - 64 logical bytes; unavailable (error answer) in largest flash mode.
// - over 100,000 cumulative writes survive through wear spreading.
// - bytes live in flash; physical slot of each byte rotates over time.
// - exactly two operations, read and write, sharing one request entry, chosen by op.
// - address is one byte; write and read data are one byte each.
// - caller's 16-byte working set saved at entry, returned at completion.
// - interrupt servicing stays enabled throughout every operation.
// - plain byte write lasts 126 to 136 microseconds.
// - every 200th write adds maintenance; that write lasts up to 58 ms.
module bns_store
  import bns_pkg::*;
#(
  parameter int LOG_N = LOG_BYTES,
  parameter int PHYS_N = PHYS_SLOTS,
  parameter int MAINT_N = MAINT_PERIOD,
  parameter int WR_US = WR_TIME_US,
  parameter int RD_US = RD_TIME_US,
  parameter int MT_US = MAINT_WAIT_US
)(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire bns_req_t req_in,
  input wire logic [15:0] flash_div,
  input wire logic big_flash_mode,
  output logic req_ready,
  output logic done,
  output bns_rsp_t rsp,
  output logic [CTX_BYTES*8-1:0] rsp_ctx,
  output logic irq_service_en
);

  typedef struct packed {
    bns_state_t state;
    bns_req_t req;
    bns_rsp_t rsp;
    logic [15:0] cyc;
    logic [15:0] us;
    logic [15:0] tot_us;
    logic [6:0] rot;
    logic [7:0] wcnt;
    logic [5:0] idx;
    logic maint;
  } bns_st_t;

  bns_st_t st_ff;
  bns_st_t nxt_st;
  logic mem_re;
  logic [6:0] mem_ra;
  logic mem_we;
  logic [6:0] mem_wa;
  logic [7:0] mem_wd;
  logic [7:0] mem_rdata;
  logic [15:0] div_eff;
  logic tick;

  // logical byte plus rotation, wrapped over the physical slots
  function automatic logic [6:0] phys(input logic [6:0] a,
                                      input logic [6:0] r);
    logic [7:0] s;
    s = {1'b0, a} + {1'b0, r};
    if (s >= 8'(PHYS_N))
    begin
      s = s - 8'(PHYS_N);
    end
    return s[6:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // flash array
  bns_mem #(
    .DEPTH(PHYS_N),
    .WIDTH(8),
    .AW(7)
  ) u_mem (
    .core_clk(core_clk),
    .rd_en(mem_re),
    .rd_addr(mem_ra),
    .wr_en(mem_we),
    .wr_addr(mem_wa),
    .wr_data(mem_wd),
    .rd_data(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // caller-set tick divider
  assign div_eff = (flash_div == 16'h0000) ? 16'h0001 : flash_div;
  assign tick = ({1'b0, st_ff.cyc} + 17'h00001) >= {1'b0, div_eff};

  always_comb
  begin
    nxt_st = st_ff;
    mem_re = 1'b0;
    mem_ra = 7'h00;
    mem_we = 1'b0;
    mem_wa = 7'h00;
    mem_wd = 8'h00;
    if (tick)
    begin
      nxt_st.cyc = 16'h0000;
      nxt_st.us = st_ff.us + 16'h0001;
      nxt_st.tot_us = st_ff.tot_us + 16'h0001;
    end
    else
    begin
      nxt_st.cyc = st_ff.cyc + 16'h0001;
    end
    case (st_ff.state)
      ST_IDLE:
      begin
        nxt_st.cyc = 16'h0000;
        nxt_st.us = 16'h0000;
        if (req_valid)
        begin
          nxt_st.req = req_in;
          nxt_st.tot_us = 16'h0000;
          nxt_st.maint = 1'b0;
          nxt_st.rsp.err = 1'b0;
          // store absent or address out of range
          if (big_flash_mode || (req_in.addr >= 8'(LOG_N)))
          begin
            nxt_st.rsp.err = 1'b1;
            nxt_st.state = ST_DONE;
          end
          else if (req_in.op == OP_WRITE)
          begin
            mem_we = 1'b1;
            mem_wa = phys(req_in.addr[6:0], st_ff.rot);
            mem_wd = req_in.wdata;
            nxt_st.state = ST_WR_WAIT;
          end
          else
          begin
            nxt_st.state = ST_RD_ISSUE;
          end
        end
      end
      ST_RD_ISSUE:
      begin
        mem_re = 1'b1;
        mem_ra = phys(st_ff.req.addr[6:0], st_ff.rot);
        nxt_st.state = ST_RD_WAIT;
      end
      ST_RD_WAIT:
      begin
        if (st_ff.us >= 16'(RD_US))
        begin
          nxt_st.rsp.rdata = mem_rdata;
          nxt_st.state = ST_DONE;
        end
      end
      ST_WR_WAIT:
      begin
        if (st_ff.us >= 16'(WR_US))
        begin
          if (st_ff.wcnt == 8'(MAINT_N - 1))
          begin
            nxt_st.wcnt = 8'h00;
            nxt_st.maint = 1'b1;
            nxt_st.idx = 6'(LOG_N - 1);
            nxt_st.state = ST_MV_RD;
          end
          else
          begin
            nxt_st.wcnt = st_ff.wcnt + 8'h01;
            nxt_st.state = ST_DONE;
          end
        end
      end
      ST_MV_RD:
      begin
        mem_re = 1'b1;
        mem_ra = phys({1'b0, st_ff.idx}, st_ff.rot);
        nxt_st.state = ST_MV_WR;
      end
      ST_MV_WR:
      begin
        // shift each byte up one slot, top first; the spare slot
        // keeps the top move from overwriting a live byte
        mem_we = 1'b1;
        mem_wa = phys({1'b0, st_ff.idx}, st_ff.rot + 7'h01);
        mem_wd = mem_rdata;
        if (st_ff.idx == 6'h00)
        begin
          // rotation spreads wear over every slot
          nxt_st.rot = (st_ff.rot == 7'(PHYS_N - 1)) ? 7'h00 :
                       st_ff.rot + 7'h01;
          nxt_st.cyc = 16'h0000;
          nxt_st.us = 16'h0000;
          nxt_st.state = ST_MT_WAIT;
        end
        else
        begin
          nxt_st.idx = st_ff.idx - 6'h01;
          nxt_st.state = ST_MV_RD;
        end
      end
      ST_MT_WAIT:
      begin
        // erase time of the maintenance pass
        if (st_ff.us >= 16'(MT_US))
        begin
          nxt_st.state = ST_DONE;
        end
      end
      ST_DONE:
      begin
        nxt_st.state = ST_IDLE;
      end
      default:
      begin
        nxt_st.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one request at a time, completion after flash work
  assign req_ready = (st_ff.state == ST_IDLE);
  assign done = (st_ff.state == ST_DONE);
  assign rsp = st_ff.rsp;
  assign rsp_ctx = st_ff.req.ctx;
  // interrupts never masked on the caller's behalf
  assign irq_service_en = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_accept;
    req_valid && req_ready;
  endsequence

  sequence s_acc_wr;
    s_accept and (req_in.op == OP_WRITE) && !big_flash_mode &&
      (req_in.addr < 8'(LOG_N));
  endsequence

  sequence s_plain_wr_done;
    done && !rsp.err && (st_ff.req.op == OP_WRITE) && !st_ff.maint;
  endsequence

  AST_UNAVAIL: assert property (
    s_accept and big_flash_mode |=> done && rsp.err)
    else $error("request in big flash mode not refused");

  AST_ADDR_RANGE: assert property (
    s_accept and (req_in.addr >= 8'(LOG_N)) |=> done && rsp.err)
    else $error("out of range address not refused");

  AST_ONE_AT_A_TIME: assert property (
    s_accept and !big_flash_mode && (req_in.addr < 8'(LOG_N))
      |=> !req_ready [*2])
    else $error("ready during an operation");

  AST_WR_TIME: assert property (
    s_plain_wr_done |-> (st_ff.tot_us >= 16'(WR_MIN_US)) &&
      (st_ff.tot_us <= 16'(WR_MAX_US)))
    else $error("byte write time out of range");

  AST_MAINT_EVERY: assert property (
    (st_ff.state == ST_WR_WAIT) && (nxt_st.state == ST_MV_RD)
      |-> st_ff.wcnt == 8'(MAINT_N - 1))
    else $error("maintenance started on wrong write");

  AST_MAINT_MAX: assert property (
    done && st_ff.maint |-> st_ff.tot_us <= 16'(MAINT_MAX_US))
    else $error("maintenance write too long");

  AST_ROTATE: assert property (
    (st_ff.state == ST_MV_WR) && (st_ff.idx == 6'h00)
      |=> (st_ff.rot != $past(st_ff.rot)) && (st_ff.state == ST_MT_WAIT))
    else $error("placement did not rotate after moves");

  AST_CTX_SAVE: assert property (
    s_accept |=> rsp_ctx == $past(req_in.ctx))
    else $error("working set not saved");

  AST_CTX_HOLD: assert property (
    !req_ready |=> $stable(rsp_ctx))
    else $error("working set changed during operation");

  AST_IRQ_OPEN: assert property (
    !req_ready |-> irq_service_en)
    else $error("interrupt service masked");

  AST_NO_EARLY_DONE: assert property (
    s_acc_wr |-> ##1 (!done) [*8])
    else $error("write completed before flash work");

endmodule // bns_store

//--- rtl/bns_pkg.sv
// shared constants and types for the byte nonvolatile store
package bns_pkg;
  // store geometry and endurance policy
  localparam int LOG_BYTES = 64;
  localparam int PHYS_SLOTS = 65;
  localparam int MAINT_PERIOD = 200;
  localparam int CTX_BYTES = 16;
  // flash timings in microseconds, counted on the flash timing tick
  localparam int WR_MIN_US = 126;
  localparam int WR_MAX_US = 136;
  localparam int WR_TIME_US = 131;
  localparam int RD_MIN_US = 71;
  localparam int RD_MAX_US = 258;
  localparam int RD_TIME_US = 100;
  localparam int MAINT_MAX_US = 58000;
  localparam int MAINT_WAIT_US = 57000;
  // core clock and the matching tick divider at this rate
  localparam int CLK_PERIOD_NS = 4;
  localparam int US_NS = 1000;
  localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RD_ISSUE = 3'h1,
    ST_RD_WAIT = 3'h2,
    ST_WR_WAIT = 3'h3,
    ST_MV_RD = 3'h4,
    ST_MV_WR = 3'h5,
    ST_MT_WAIT = 3'h6,
    ST_DONE = 3'h7
  } bns_state_t;

  typedef enum logic {
    OP_READ = 1'b0,
    OP_WRITE = 1'b1
  } bns_op_t;

  typedef struct packed {
    bns_op_t op;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [CTX_BYTES*8-1:0] ctx;
  } bns_req_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic err;
  } bns_rsp_t;
endpackage

//--- rtl/bns_mem.sv
// flash array model: one write port, one registered read port
module bns_mem
  import bns_pkg::*;
#(
  parameter int DEPTH = PHYS_SLOTS,
  parameter int WIDTH = 8,
  parameter int AW = 7
)(
  input wire logic core_clk,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] rd_data
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] arr;
    logic [WIDTH-1:0] rdata;
  } bns_mem_st_t;

  bns_mem_st_t mem_ff;
  bns_mem_st_t nxt_mem;

  // contents survive reset, as flash does
  always_comb
  begin
    nxt_mem = mem_ff;
    if (rd_en && (32'(rd_addr) < DEPTH))
    begin
      nxt_mem.rdata = mem_ff.arr[rd_addr];
    end
    if (wr_en && (32'(wr_addr) < DEPTH))
    begin
      nxt_mem.arr[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge core_clk)
  begin
    mem_ff <= nxt_mem;
  end

  assign rd_data = mem_ff.rdata;

endmodule // bns_mem

//--- testbench/bns_core_model.sv
// processor core model that calls the store one request at a time
module bns_core_model
  import bns_pkg::*;
(
  input wire logic core_clk,
  input wire logic req_ready,
  input wire logic done,
  input wire bns_rsp_t rsp,
  input wire logic [CTX_BYTES*8-1:0] rsp_ctx,
  output logic req_valid,
  output bns_req_t req_in
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    req_valid = 1'b0;
    req_in = '0;
  end

  ////////////////////////////////////////////////////////////////////////
  // one call in flight
  task automatic call(input bns_req_t r, output bns_rsp_t o,
    output logic [CTX_BYTES*8-1:0] c, output int n);
    logic rdy;
    @(posedge core_clk);
    #1;
    req_valid = 1'b1;
    req_in = r;
    rdy = req_ready;
    while (rdy !== 1'b1)
    begin
      @(posedge core_clk);
      #1;
      rdy = req_ready;
    end
    @(posedge core_clk);
    #1;
    // released lines carry no stale copy of the request
    req_valid = 1'b0;
    req_in = ~r;
    n = 0;
    // longest call here is a maintenance write of a few hundred cycles
    while (done !== 1'b1 && n < 2000)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    o = rsp;
    c = rsp_ctx;
  endtask
endmodule // bns_core_model

//--- testbench/bns_store_tb.sv
// self-checking bench for the byte nonvolatile store
module bns_store_tb
  import bns_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // short maintenance period and wait keep the run brief
  localparam int MN = 3;
  localparam int MT = 20;
  logic core_clk, reset, req_valid, big_flash_mode;
  logic req_ready, done, irq_service_en;
  logic [15:0] flash_div;
  bns_req_t req_in;
  bns_rsp_t rsp;
  logic [CTX_BYTES*8-1:0] rsp_ctx;
  int bad_count, n_compared, wr_cnt, dv;
  logic [7:0] mem [64];
  bit [63:0] known;

  always #2 core_clk = ~core_clk;

  bns_store #(.MAINT_N(MN), .MT_US(MT)) dut (.core_clk(core_clk),
    .reset(reset), .req_valid(req_valid), .req_in(req_in),
    .flash_div(flash_div), .big_flash_mode(big_flash_mode),
    .req_ready(req_ready), .done(done), .rsp(rsp), .rsp_ctx(rsp_ctx),
    .irq_service_en(irq_service_en));

  bns_core_model core (.core_clk(core_clk), .req_ready(req_ready),
    .done(done), .rsp(rsp), .rsp_ctx(rsp_ctx), .req_valid(req_valid),
    .req_in(req_in));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk_val(input logic [127:0] got, input logic [127:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic chk_time(input int n, input int lo, input int hi);
    n_compared++;
    if (n < lo || n > hi)
    begin
      bad_count++;
      $display("ERROR t=%0t cycles=%0h range=%0h..%0h", $time, n, lo, hi);
    end
  endtask

  task automatic report_and_stop;
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one call, checked against the byte array model
  task automatic do_op(input bns_op_t op, input logic [7:0] a);
    bns_req_t r;
    bns_rsp_t o;
    logic [CTX_BYTES*8-1:0] c;
    int n;
    int lo;
    int hi;
    r.op = op;
    r.addr = a;
    r.wdata = 8'($urandom);
    r.ctx = {$urandom, $urandom, $urandom, $urandom};
    core.call(r, o, c, n);
    chk_val(c, r.ctx);
    chk_val(irq_service_en, 1'b1);
    if (big_flash_mode || a >= LOG_BYTES)
    begin
      chk_val(o.err, 1'b1);
      chk_time(n, 0, 1);
    end
    else if (op == OP_WRITE)
    begin
      chk_val(o.err, 1'b0);
      mem[a[5:0]] = r.wdata;
      known[a[5:0]] = 1'b1;
      wr_cnt++;
      // ticks scale with the divider; the slot moves run at core rate
      lo = WR_MAX_US * dv + 2;
      hi = (WR_MAX_US + MT) * dv + 2 * LOG_BYTES + 8;
      if (wr_cnt % MN == 0)
        chk_time(n, lo, hi);
      else
        chk_time(n, WR_MIN_US * dv, WR_MAX_US * dv + 1);
    end
    else
    begin
      chk_val(o.err, 1'b0);
      if (known[a[5:0]])
        chk_val(o.rdata, mem[a[5:0]]);
      chk_time(n, RD_MIN_US * dv, RD_MAX_US * dv + 1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    reset = 1'b1;
    big_flash_mode = 1'b0;
    flash_div = 16'h0001;
    dv = 1;
    bad_count = 0;
    n_compared = 0;
    wr_cnt = 0;
    known = '0;
    void'($urandom(32'hEFF1));
    repeat (2) @(posedge core_clk);
    #1;
    reset = 1'b0;
    chk_val(req_ready, 1'b1);
    chk_val(done, 1'b0);
    chk_val(rsp, 9'h000);
    do_op(OP_WRITE, 8'h00);
    do_op(OP_WRITE, 8'h3F);
    for (int i = 0; i < 7; i++)
      do_op(OP_WRITE, 8'($urandom_range(63)));
    for (int i = 0; i < 64; i++)
      if (known[i])
        do_op(OP_READ, 8'(i));
    $display("test 1 done: fill and read back across maintenance");
    for (int i = 0; i < 24; i++)
    begin
      if ($urandom_range(5) == 0)
        do_op(bns_op_t'($urandom_range(1)), 8'($urandom_range(255, 64)));
      else
        do_op(bns_op_t'($urandom_range(1)), 8'($urandom_range(63)));
    end
    $display("test 2 done: random mixed calls");
    do_op(OP_WRITE, 8'h40);
    do_op(OP_READ, 8'hFF);
    big_flash_mode = 1'b1;
    do_op(OP_WRITE, 8'h00);
    do_op(OP_READ, 8'h3F);
    big_flash_mode = 1'b0;
    do_op(OP_READ, 8'h00);
    do_op(OP_READ, 8'h3F);
    $display("test 3 done: refused calls leave the store intact");
    // slower divider, then zero, which acts as one
    flash_div = 16'h0002;
    dv = 2;
    for (int i = 0; i < 3; i++)
      do_op(OP_WRITE, 8'($urandom_range(63)));
    do_op(OP_READ, 8'h00);
    flash_div = 16'h0000;
    dv = 1;
    do_op(OP_WRITE, 8'h3F);
    do_op(OP_READ, 8'h3F);
    $display("test 4 done: flash divider settings");
    report_and_stop();
  end

  initial
  begin
    // calls take some 7,000 cycles; about seven-fold margin, well inside budget
    #200000;
    bad_count++;
    $display("ERROR t=%0t watchdog got=%0h exp=%0h", $time, 1, 0);
    report_and_stop();
  end
endmodule // bns_store_tb
